// ===== rtl/cso_decode.v
// Purpose: chip-select option decode, region match and acknowledge
// Assumes: access request from processor logic on clk, one at a time
// Notes:   twelve pins; regions 0..5 own a base word, pins 6..11 strobe
//
// Overview of operation
// - data-only region refuses instruction fetches
// - write-protected region refuses writes
// - cache-inhibit flag marks the access not cacheable
// - acknowledge enable makes the block drive both acknowledges
// - wait-state field delays first transfer acknowledge 0 to 7 cycles
// - port width 01 is 16-bit, 10 is 32-bit, others reserved
// - pin function: chip enable, write strobe, output strobe, alternate
// - only the boot pin and pins one to five can be chip enables
// - write strobe follows one selected byte lane
// - region field ties a strobe pin to region zero to five
// - size code zero keeps the chip select idle
// - size code n compares address bits 31 down to 11+n
// - regions one, three, five nest in zero, two, four
// - types 0000 and 0001 are asynchronous, one or two turn-off
// - types 0010 and 0011 are synchronous with async or sync strobe
// - types 0101 and 0111 are fixed bursts on burst timing
// - type 1000 is final-beat burst with no output strobe
// - type 1001 acts like 0011 and lets accesses overlap
// - sub-block flag makes region one, three or five a nested sub-block
// - supervisor-only flag refuses user-mode accesses
//
// limitations
// - one access in flight; the next waits for ready
// - base words exist for regions zero to five only
// - pins six to eleven never act as chip enables
// - output strobe pins assert on reads only
// - reserved codes give undefined but harmless behaviour
// - region codes six and seven never match a region
// - lowest matching region wins when two overlap, but a flagged sub-block beats its main block
// - a sub-block needs its main block to match as well
// - refused or unmatched accesses raise an error pulse
// - refused accesses drive no pin and no acknowledge
// - attributes stay from the last taken access
// - option words reset to alternate pin use
// - read data is zero outside its slot
// - status word layout is local, not part of the option map
// - no interrupt of its own; errors leave through a port
`timescale 1ns/1ps
`include "cso_defs.vh"

module cso_decode #(
    parameter NPIN = `CSO_NPIN,
    parameter NREG = `CSO_NREG
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire [4:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        acc_valid,
    output wire        acc_ready,
    input  wire [31:0] acc_addr,
    input  wire        acc_write,
    input  wire        acc_fetch,
    input  wire        acc_super,
    input  wire [3:0]  acc_be,
    output reg         address_ack,
    output reg         transfer_ack,
    output reg         acc_error,
    output reg         acc_nocache,
    output reg         acc_port16,
    output reg  [3:0]  acc_interface_type,
    output reg         acc_burst,
    output reg         acc_final_beat,
    output reg         acc_sync_oe,
    output reg  [NPIN-1:0] pin_n,
    output reg  [NPIN-1:0] pin_alt
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_DONE = 2'h2;
localparam ST_REC  = 2'h3;

// ----------------------------------------
// registers
// ----------------------------------------
reg  [31:0]     opt_q  [0:NPIN-1];
reg  [19:0]     base_q [0:NREG-1];
reg  [1:0]      st_q;
reg  [2:0]      cnt_q;
reg  [2:0]      sel_q;
reg             hit_q;
reg             wr_q;
reg  [3:0]      be_q;
reg             ack_en_q;
reg  [3:0]      ity_q;

wire [NREG-1:0] raw_hit;
wire [NREG-1:0] eff_hit;
wire [NPIN-1:0] pin_on;
reg  [2:0]      sel_d;
reg             any_d;
reg  [31:0]     o_sel;
reg             deny;
reg  [31:0]     rd_d;
integer         k_sel;
integer         k_rd;

// ----------------------------------------
// region match per base word
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
        wire [3:0]  bs = opt_q[g][`CSO_BLOCK_SIZE_CODE];
        // low bits below the block size are don't-care
        wire [19:0] msk = ~((20'h00001 << (bs - 4'h1)) - 20'h00001);
        assign raw_hit[g] = (bs != `CSO_BS_OFF) &&
            (((acc_addr[31:12] ^ base_q[g]) & msk) == 20'h00000);
        if (g % 2 == 1) begin : g_sub
            // a sub-block only counts inside its paired main block
            assign eff_hit[g] = raw_hit[g] &&
                (!opt_q[g][`CSO_SUB_BLOCK_FLAG] || raw_hit[g-1]);
        end else begin : g_main
            // the nested sub-block overrides its main block
            assign eff_hit[g] = raw_hit[g] &&
                !(raw_hit[g+1] && opt_q[g+1][`CSO_SUB_BLOCK_FLAG]);
        end
    end
endgenerate

// ----------------------------------------
// select the lowest matching region
// ----------------------------------------
always @* begin
    sel_d = 3'h0;
    any_d = 1'b0;
    for (k_sel = NREG - 1; k_sel >= 0; k_sel = k_sel - 1) begin
        if (eff_hit[k_sel]) begin
            sel_d = k_sel[2:0];
            any_d = 1'b1;
        end
    end
end

// ----------------------------------------
// attributes and protection of the region
// ----------------------------------------
always @* begin
    o_sel = opt_q[sel_d];
    deny  = (acc_fetch && o_sel[`CSO_DSP]) ||
            (acc_write && o_sel[`CSO_WP]) ||
            (!acc_super && o_sel[`CSO_SUPERVISOR_ONLY_FLAG]);
end

// ----------------------------------------
// pin function per pin
// ----------------------------------------
generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
        wire [1:0] pc  = opt_q[g][`CSO_PIN_FUNCTION_SELECT];
        wire [2:0] rg  = opt_q[g][`CSO_REGION];
        wire [1:0] ln  = opt_q[g][`CSO_BYTE];
        // strobes follow the region their field names
        wire       rgm = hit_q && (rg == sel_q) && (rg < 3'h6);
        wire       ce  = (g < NREG) && hit_q && (sel_q == g);
        wire       we  = rgm && wr_q && be_q[ln];
        // final-beat bursts get no output strobe
        wire       oe  = rgm && !wr_q &&
                         (ity_q != `CSO_IT_LAST);
        assign pin_on[g] = (pc == `CSO_PC_CE) ? ce :
                           (pc == `CSO_PC_WE) ? we :
                           (pc == `CSO_PC_OE) ? oe : 1'b0;
    end
endgenerate

// one-cycle overlap only for the overlapping synchronous type
assign acc_ready = (st_q == ST_IDLE) ||
    ((st_q == ST_DONE) && (ity_q == `CSO_IT_OVLP));

// ----------------------------------------
// access sequencer
// ----------------------------------------
// timing of one access, taken at edge c0:
//   c1       address and, with no waits, transfer acknowledge
//   c1+w     transfer acknowledge after w wait states
//   c2..c2+w select pins low, one cycle after the region latch
//   done     one idle clock more after type 0001 only, for slow turn-off buffers
// the overlapping type accepts its next access in the done cycle
// the acknowledges are single pulses; external devices must
// supply them when the acknowledge enable is clear
// a refused access ends at c1 with the error pulse alone
// the sequencer state reads back through the status word
// so software can spot a stuck access
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        st_q           <= ST_IDLE;
        cnt_q          <= 3'h0;
        sel_q          <= 3'h0;
        hit_q          <= 1'b0;
        wr_q           <= 1'b0;
        be_q           <= 4'h0;
        ack_en_q       <= 1'b0;
        ity_q          <= `CSO_IT_ASYNC1;
        address_ack    <= 1'b0;
        transfer_ack   <= 1'b0;
        acc_error      <= 1'b0;
        acc_nocache    <= 1'b0;
        acc_port16     <= 1'b0;
        acc_interface_type      <= `CSO_IT_ASYNC1;
        acc_burst      <= 1'b0;
        acc_final_beat <= 1'b0;
        acc_sync_oe    <= 1'b0;
    end else begin
        address_ack  <= 1'b0;
        transfer_ack <= 1'b0;
        acc_error    <= 1'b0;
        if (acc_valid && acc_ready) begin
            // a refused or unmatched access raises an error, no pins
            hit_q     <= any_d && !deny;
            acc_error <= !any_d || deny;
            sel_q     <= sel_d;
            wr_q      <= acc_write;
            be_q      <= acc_be;
            ack_en_q  <= o_sel[`CSO_ACKNOWLEDGE_RETURN_ENABLE];
            ity_q     <= o_sel[`CSO_INTERFACE_TYPE];
            acc_interface_type <= o_sel[`CSO_INTERFACE_TYPE];
            acc_nocache <= o_sel[`CSO_CI];
            acc_port16  <= (o_sel[`CSO_PS] == `CSO_PS_16);
            acc_burst   <= (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_BURST_IN_PROGRESS_TIMING_A) ||
                           (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_BURST_IN_PROGRESS_TIMING_S) ||
                           (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_LAST);
            acc_final_beat <= (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_LAST);
            acc_sync_oe <= (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_SYNC_S) ||
                           (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_BURST_IN_PROGRESS_TIMING_S) ||
                           (o_sel[`CSO_INTERFACE_TYPE] == `CSO_IT_OVLP);
            if (any_d && !deny) begin
                address_ack  <= o_sel[`CSO_ACKNOWLEDGE_RETURN_ENABLE];
                transfer_ack <= o_sel[`CSO_ACKNOWLEDGE_RETURN_ENABLE] &&
                                (o_sel[`CSO_FIRST_ACK_WAIT_STATES] == 3'h0);
                cnt_q <= o_sel[`CSO_FIRST_ACK_WAIT_STATES];
                st_q  <= (o_sel[`CSO_FIRST_ACK_WAIT_STATES] == 3'h0) ? ST_DONE : ST_WAIT;
            end else begin
                st_q <= ST_IDLE;
            end
        end else begin
            case (st_q)
                ST_WAIT: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        transfer_ack <= ack_en_q;
                        st_q         <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    hit_q <= 1'b0;
                    // slow buffers need a second idle clock
                    st_q <= (ity_q == `CSO_IT_ASYNC2) ? ST_REC :
                            ST_IDLE;
                end
                ST_REC: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    hit_q <= 1'b0;
                    st_q  <= ST_IDLE;
                end
            endcase
        end
    end
end

// ----------------------------------------
// pin drivers, active low
// ----------------------------------------
// registered so a decode glitch never reaches a pad
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        pin_n <= {NPIN{1'b1}};
    end else begin
        pin_n <= ~pin_on;
    end
end

// ----------------------------------------
// alternate-function flags, one per pin
// ----------------------------------------
generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_alt
        // pad mux select; clear during reset, then alternate for a pin left at reset
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_alt[g] <= 1'b0;
            end else begin
                pin_alt[g] <= (opt_q[g][`CSO_PIN_FUNCTION_SELECT] == `CSO_PC_ALT);
            end
        end
    end
endgenerate

// ----------------------------------------
// option words, one writer per pin
// ----------------------------------------
generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_opt
        localparam [4:0] IDX = g;
        // each word decodes its own index
        wire hit_w = reg_wr && (reg_addr == `CSO_IDX_OPT0 + IDX);
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                opt_q[g] <= `CSO_OPT_RST;
            end else if (hit_w) begin
                // reserved bits stay zero, so reads show them as zero
                opt_q[g] <= reg_wdata & `CSO_OPT_MASK;
            end
        end
    end
endgenerate

// ----------------------------------------
// base words, regions zero to five only
// ----------------------------------------
generate
    for (g = 0; g < NREG; g = g + 1) begin : g_base
        localparam [4:0] IDX = g;
        // only the compared bits are kept; the rest read as zero
        wire hit_w = reg_wr && (reg_addr == `CSO_IDX_BASE0 + IDX);
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                base_q[g] <= `CSO_BASE_RST;
            end else if (hit_w) begin
                base_q[g] <= reg_wdata[31:12];
            end
        end
    end
endgenerate

// ----------------------------------------
// read mux, selected before the clock
// ----------------------------------------
// unmapped indices fall through to zero
always @* begin
    rd_d = 32'h00000000;
    for (k_rd = 0; k_rd < NPIN; k_rd = k_rd + 1) begin
        if (reg_addr == `CSO_IDX_OPT0 + k_rd[4:0]) begin
            rd_d = opt_q[k_rd];
        end
    end
    for (k_rd = 0; k_rd < NREG; k_rd = k_rd + 1) begin
        if (reg_addr == `CSO_IDX_BASE0 + k_rd[4:0]) begin
            rd_d = {base_q[k_rd], 12'h000};
        end
    end
    if (reg_addr == `CSO_IDX_STAT) begin
        // live sequencer state for software debug
        rd_d = {24'h000000, hit_q, sel_q, 2'h0, st_q};
    end
end

// ----------------------------------------
// read data, one cycle after the strobe
// ----------------------------------------
// zero outside the slot so a stale word is never mistaken
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        reg_rdata <= rd_d;
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule

// ===== shared/cso_defs.vh
// Purpose: constants of the chip-select option decoder
// Assumes: 32-bit option words, bit 31 is the leftmost field bit
// Notes:   definitions only
`ifndef CSO_DEFS_VH
`define CSO_DEFS_VH
// ----------------------------------------
// register indices (word offset = 4 * index)
// ----------------------------------------
`define CSO_IDX_OPT0    5'h00
`define CSO_IDX_BASE0   5'h0c
`define CSO_IDX_STAT    5'h12
`define CSO_NPIN        12
`define CSO_NREG        6
// ----------------------------------------
// option field positions
// ----------------------------------------
`define CSO_BLOCK_SIZE_CODE       31:28
`define CSO_SUB_BLOCK_FLAG        27
`define CSO_SUPERVISOR_ONLY_FLAG        26
`define CSO_DSP         25
`define CSO_WP          24
`define CSO_CI          23
`define CSO_ACKNOWLEDGE_RETURN_ENABLE       18
`define CSO_FIRST_ACK_WAIT_STATES       17:15
`define CSO_PS          14:13
`define CSO_PIN_FUNCTION_SELECT        12:11
`define CSO_BYTE        10:9
`define CSO_REGION      8:6
`define CSO_INTERFACE_TYPE       3:0
`define CSO_OPT_MASK    32'hff87ffcf
`define CSO_OPT_RST     32'h00001800
`define CSO_BASE_RST    20'h00000
// ----------------------------------------
// field codes
// ----------------------------------------
`define CSO_BS_OFF      4'h0
`define CSO_PS_16       2'h1
`define CSO_PS_32       2'h2
`define CSO_PC_CE       2'h0
`define CSO_PC_WE       2'h1
`define CSO_PC_OE       2'h2
`define CSO_PC_ALT      2'h3
`define CSO_IT_ASYNC1   4'h0
`define CSO_IT_ASYNC2   4'h1
`define CSO_IT_SYNC_A   4'h2
`define CSO_IT_SYNC_S   4'h3
`define CSO_IT_BURST_IN_PROGRESS_TIMING_A   4'h5
`define CSO_IT_BURST_IN_PROGRESS_TIMING_S   4'h7
`define CSO_IT_LAST     4'h8
`define CSO_IT_OVLP     4'h9
`endif

// ===== verif/cso_decode_assertions.sv
// Purpose: port assertions of the chip-select option decoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the decoder at the foot of this file
`timescale 1ns/1ps
module cso_decode_assertions #(
    parameter NPIN = 12
) (
    input wire            clk,
    input wire            arst_n,
    input wire            reg_rd,
    input wire [31:0]     reg_rdata,
    input wire            acc_valid,
    input wire            acc_ready,
    input wire            address_ack,
    input wire            transfer_ack,
    input wire            acc_error,
    input wire [3:0]      acc_interface_type,
    input wire [NPIN-1:0] pin_n
);
    // ------------------------------
    // properties
    // ------------------------------
    // one domain, so one clock and one reset serve all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    rd_slot_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    err_quiet_a:
    assert property (acc_error |-> !address_ack && !transfer_ack ##1 &pin_n)
        else $error("refused access still acknowledged or selected");
    ack_wait_a:
    assert property (address_ack |-> ##[0:7] transfer_ack)
        else $error("transfer acknowledge later than seven waits");
    ack_pulse_a:
    assert property (address_ack |=> !address_ack)
        else $error("address acknowledge longer than one cycle");
    ack_cause_a:
    assert property (address_ack |-> $past(acc_valid && acc_ready))
        else $error("address acknowledge without a taken access");
    busy_ready_a:
    assert property (address_ack && acc_interface_type != 4'h9 |-> !acc_ready)
        else $error("new access taken while busy");
    sel_after_a:
    assert property (transfer_ack |=> !(&pin_n))
        else $error("no select pin after transfer acknowledge");
    sel_cause_a:
    assert property ($fell(&pin_n) |-> $past(acc_valid && acc_ready, 2))
        else $error("select pin without a taken access");
    cover property (address_ack && transfer_ack);
    cover property (acc_error);
    cover property ($fell(&pin_n));
    cover property (address_ack && acc_ready);
endmodule

bind cso_decode cso_decode_assertions #(.NPIN(NPIN)) u_chk (
    .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_ready(acc_ready),
    .address_ack(address_ack), .transfer_ack(transfer_ack),
    .acc_error(acc_error), .acc_interface_type(acc_interface_type), .pin_n(pin_n));

// ===== verif/cso_mem_model.sv
// Purpose: far-side devices watching the select pins
// Assumes: pins active low, sampled on clk
// Notes:   keeps a log of pins driven low since the last clear
`timescale 1ns/1ps
module cso_mem_model (
    input wire        clk,
    input wire        arst_n,
    input wire        clr,
    input wire [11:0] pin_n,
    output reg [11:0] seen_q
);
    // ------------------------------
    // select log
    // ------------------------------
    // sticky, so a one-cycle strobe cannot slip past the bench
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_q <= 12'h000;
        end else if (clr) begin
            seen_q <= 12'h000;
        end else begin
            seen_q <= seen_q | ~pin_n;
        end
    end
endmodule

// ===== verif/cso_decode_bench.sv
// Purpose: self-checking bench of the chip-select option decoder
// Assumes: default pin and region counts of the decoder
// Notes:   pin activity is read from the far-side log
`timescale 1ns/1ps
`include "cso_defs.vh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module cso_decode_bench;
    // ------------------------------
    // signals
    // ------------------------------
    reg         clk = 1'h0, arst_n = 1'h0, clr = 1'h0;
    reg         reg_wr = 1'h0, reg_rd = 1'h0, acc_valid = 1'h0;
    reg         acc_write = 1'h0, acc_fetch = 1'h0, acc_super = 1'h0;
    reg  [4:0]  reg_addr = 5'h00;
    reg  [3:0]  acc_be = 4'h0, it;
    reg  [31:0] reg_wdata = 32'h0, acc_addr = 32'h0;
    reg  [6:0]  ex;
    wire [31:0] reg_rdata;
    wire [3:0]  acc_interface_type;
    wire [11:0] pin_n, pin_alt, mk;
    wire        acc_ready, address_ack, transfer_ack, acc_error;
    wire        acc_nocache, acc_port16, acc_burst, acc_final_beat;
    wire        acc_sync_oe;
    integer     errors = 0, n_checks = 0, cyc = 0, aa, ta, er, i;
    localparam  [31:0] ba = 32'h00100000;
    cso_decode u_dut (.*);
    cso_mem_model u_mem (.clk(clk), .arst_n(arst_n), .clr(clr),
        .pin_n(pin_n), .seen_q(mk));
    // clock, and a guard against a hang
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            print_verdict;
        end
    end
    // ------------------------------
    // bus tasks
    // ------------------------------
    // cfg builds defined codes only; the all-ones write to word 0 programs reserved ones
    function [31:0] cfg(input [3:0] bs, input [4:0] at, input [2:0] w,
        input [1:0] pf, input [1:0] ln, input [3:0] ty);
        cfg = {bs, at, 4'h0, 1'h1, w, 2'h2, pf, ln, 5'h00, ty};
    endfunction
    task wr(input [4:0] a, input [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input [4:0] a, input [31:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        `CHK("register", e, reg_rdata)
    endtask
    // boot region option with the pin as chip enable
    task ce(input [3:0] bs, input [4:0] at, input [2:0] w, input [3:0] ty);
        wr(5'h00, cfg(bs, at, w, `CSO_PC_CE, 2'h0, ty));
    endtask
    // one access; ack offsets counted from the first answer cycle
    task acc(input [31:0] a, input [2:0] f, input [3:0] be);
        integer k;
        {aa, ta, er} = {32'd99, 32'd99, 32'd0};
        @(posedge clk);
        {clr, acc_valid, acc_addr, acc_be} <= {2'h3, a, be};
        {acc_write, acc_fetch, acc_super} <= f;
        @(posedge clk);
        {clr, acc_valid} <= 2'h0;
        for (k = 0; k < 12; k++) begin
            #1;
            if (address_ack === 1'h1) aa = k;
            if (transfer_ack === 1'h1) ta = k;
            if (acc_error === 1'h1) er = 1;
            @(posedge clk);
        end
    endtask
    task refuse(input [4:0] at, input [2:0] f);
        ce(4'h1, at, 3'h0, 4'h0);
        acc(ba, f, 4'hf);
        `CHK("refused", 13'h1000, {er[0], mk})
        acc(ba, 3'h1, 4'hf);
        `CHK("allowed", 13'h0001, {er[0], mk})
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------
    // tests
    // ------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        for (i = 0; i < 12; i++) rd(i[4:0], `CSO_OPT_RST);
        wr(5'h13, 32'hffffffff);
        rd(5'h13, 32'h0);
        wr(5'h00, 32'hffffffff);
        rd(5'h00, `CSO_OPT_MASK);
        wr(5'h0c, ba);
        ce(4'h0, 5'h00, 3'h0, 4'h0);
        acc(ba, 3'h1, 4'hf);
        `CHK("size off", 13'h1000, {er[0], mk})
        for (i = 1; i < 4; i++) begin
            ce(i[3:0], 5'h00, 3'h0, 4'h0);
            acc(ba + (32'h800 << i) - 4, 3'h1, 4'hf);
            `CHK("inside", 0, er)
            acc(ba + (32'h800 << i), 3'h1, 4'hf);
            `CHK("beyond", 1, er)
        end
        for (i = 0; i < 8; i++) begin
            ce(4'h1, 5'h00, i[2:0], 4'h0);
            acc(ba, 3'h1, 4'hf);
            `CHK("waits", i, ta - aa)
            `CHK("ce pin", 12'h001, mk)
        end
        // acknowledge off, 16-bit port, not cacheable
        wr(5'h00, cfg(4'h1, 5'h01, 3'h0, `CSO_PC_CE, 2'h0, 4'h0) ^ 32'h46000);
        acc(ba, 3'h1, 4'hf);
        `CHK("no ack", 198, aa + ta)
        `CHK("attrs", 2'h3, {acc_nocache, acc_port16})
        refuse(5'h04, 3'h3);
        refuse(5'h02, 3'h5);
        refuse(5'h08, 3'h0);
        `CHK("attrs", 2'h0, {acc_nocache, acc_port16})
        for (i = 0; i < 8; i++) begin
            it = 4'(32'h98753210 >> (4 * i));
            ex = {it, it == 4'h5 || it == 4'h7 || it == 4'h8, it == 4'h8,
                it == 4'h3 || it == 4'h7 || it == 4'h9};
            ce(4'h1, 5'h00, 3'h0, it);
            acc(ba, 3'h1, 4'hf);
            `CHK("type", ex, {acc_interface_type, acc_burst, acc_final_beat, acc_sync_oe})
        end
        ce(4'h2, 5'h00, 3'h0, 4'h0);
        wr(5'h0d, ba + 32'h1000);
        wr(5'h01, cfg(4'h1, 5'h10, 3'h0, `CSO_PC_CE, 2'h0, 4'h0));
        acc(ba + 32'h1000, 3'h1, 4'hf);
        `CHK("sub", 12'h002, mk)
        acc(ba, 3'h1, 4'hf);
        `CHK("main", 12'h001, mk)
        wr(5'h06, cfg(4'h0, 5'h00, 3'h0, `CSO_PC_WE, 2'h2, 4'h0));
        wr(5'h07, cfg(4'h0, 5'h00, 3'h0, `CSO_PC_OE, 2'h0, 4'h0));
        wr(5'h08, cfg(4'h1, 5'h00, 3'h0, `CSO_PC_CE, 2'h0, 4'h0));
        @(posedge clk);
        #1;
        `CHK("alt", 2'h2, {pin_alt[9], pin_alt[6]})
        acc(ba, 3'h5, 4'h4);
        `CHK("lane", 12'h041, mk)
        acc(ba, 3'h5, 4'h1);
        `CHK("other lane", 12'h001, mk)
        acc(ba, 3'h5, 4'hf);
        `CHK("word", 12'h041, mk)
        acc(ba, 3'h1, 4'hf);
        `CHK("read strobe", 12'h081, mk)
        ce(4'h2, 5'h00, 3'h0, `CSO_IT_LAST);
        acc(ba, 3'h1, 4'hf);
        `CHK("no strobe", 12'h001, mk)
        rd(`CSO_IDX_STAT, 32'h0);
        print_verdict;
    end
endmodule
